// ---- audio_mux_pkg.sv ----
// Constants and carrier types for the dual host audio port pin mux
`default_nettype none
package audio_mux_pkg;

  // ---------------------------------------------------------------
  // Field codes
  // ---------------------------------------------------------------
  localparam logic [2:0] SOUT_PRIM_DATA = 3'h1;
  localparam logic [2:0] SOUT_SEC_BIT = 3'h6;
  localparam logic [2:0] SOUT_SEC_FRAME = 3'h7;
  localparam logic [2:0] PIN_SRC_GENERAL = 3'h0;
  localparam logic [2:0] PIN_SRC_SOUT = 3'h3;
  localparam logic [1:0] SEC_DIN_GENERAL = 2'h0;
  localparam logic [3:0] GP_SEC_INPUT = 4'h1;
  localparam logic [3:0] GP_REC_FRAME = 4'h7;
  localparam logic [3:0] GP_SEC_BIT = 4'h8;
  localparam logic [3:0] GP_SEC_FRAME = 4'h9;
  localparam logic [3:0] GP_SEC_DOUT = 4'hb;
  localparam logic [1:0] FRAME_SRC_PLAY = 2'h0;
  localparam logic [1:0] FRAME_SRC_REC = 2'h1;
  localparam logic [1:0] FRAME_SRC_OTHER = 2'h2;
  localparam int SYNC_STAGES = 2;
  localparam int PIN_COUNT = 5;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic prim_frame_dir;
    logic prim_bit_dir;
    logic [1:0] prim_frame_src;
    logic prim_bit_src;
    logic [1:0] sec_frame_src;
    logic sec_bit_src;
    logic iface_din_sel;
    logic prim_dout_sel;
    logic sec_dout_sel;
    logic [2:0] sout_func;
    logic [2:0] sec_frame_pin;
    logic [2:0] sec_bit_pin;
    logic [1:0] sec_din_pin;
    logic [3:0] gp_func;
    logic [2:0] rec_frame_pin;
    logic rec_frame_sel;
  } mux_cfg_s;

  typedef struct packed {
    logic oe;
    logic level;
  } pin_drive_s;

  localparam mux_cfg_s CFG_RESET = '0;
  localparam pin_drive_s PIN_IDLE = '0;

endpackage

`default_nettype wire

// ---- audio_port_dual_host_mux.sv ----
// Dual host audio serial port pin mux with config crossing into link domain
`timescale 1ns/10ps
`default_nettype none

module audio_port_dual_host_mux (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire audio_mux_pkg::mux_cfg_s cfg_i,
  output logic cfg_busy_o,
  input wire logic link_clk_i,
  input wire logic playback_rate_clock_i,
  input wire logic record_rate_clock_i,
  input wire logic int_bit_clock_i,
  input wire logic iface_dout_i,
  input wire logic prim_frame_pin_i,
  output logic prim_frame_pin_o,
  output logic prim_frame_pin_oe_o,
  input wire logic prim_bit_pin_i,
  output logic prim_bit_pin_o,
  output logic prim_bit_pin_oe_o,
  input wire logic prim_din_pin_i,
  input wire logic sout_pin_i,
  output logic sout_pin_o,
  output logic sout_pin_oe_o,
  input wire logic general_pin_one_i,
  output logic general_pin_one_o,
  output logic general_pin_one_oe_o,
  output logic iface_frame_o,
  output logic iface_bit_o,
  output logic iface_din_o,
  output logic rec_frame_o
);

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------

  // General pin acts as secondary input only in its input function
  function automatic logic gp_is_input(input logic [3:0] func);
    gp_is_input = (func == audio_mux_pkg::GP_SEC_INPUT);
  endfunction

  // Three-way frame clock source pick; unused code falls back to playback
  function automatic logic frame_pick(input logic [1:0] sel, input logic play,
                                      input logic rec, input logic other);
    frame_pick = (sel == audio_mux_pkg::FRAME_SRC_REC) ? rec :
                 (sel == audio_mux_pkg::FRAME_SRC_OTHER) ? other : play;
  endfunction

  // ---------------------------------------------------------------
  // Control domain: config capture and toggle request
  // ---------------------------------------------------------------
  audio_mux_pkg::mux_cfg_s cfg_hold_q;
  logic req_tgl_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic cfg_busy_q;
  logic seen_q;
  wire logic pending = (req_tgl_q != ack_s2_q);
  wire logic cfg_changed = (cfg_i != cfg_hold_q);
  wire logic launch = !pending && cfg_changed;

  // Hold word stays frozen while a transfer is in flight, so the link
  // side never loads a half-changed config
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      cfg_hold_q <= audio_mux_pkg::CFG_RESET;
      req_tgl_q <= 1'b0;
    end else if (launch) begin
      cfg_hold_q <= cfg_i;
      req_tgl_q <= ~req_tgl_q;
    end
  end

  // Acknowledge toggle back from the link domain
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= seen_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  // Busy while a change waits or travels
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      cfg_busy_q <= 1'b0;
    end else begin
      cfg_busy_q <= pending || cfg_changed;
    end
  end

  assign cfg_busy_o = cfg_busy_q;

  // ---------------------------------------------------------------
  // Link domain: reset and request synchronisers
  // ---------------------------------------------------------------
  logic link_rst_s1_q;
  logic link_rstn_q;
  logic req_s1_q;
  logic req_s2_q;
  audio_mux_pkg::mux_cfg_s cfg_q;
  wire logic cfg_load = (req_s2_q != seen_q);

  // Reset is brought across so the link side leaves reset cleanly
  always_ff @(posedge link_clk_i) begin
    link_rst_s1_q <= rstn_i;
    link_rstn_q <= link_rst_s1_q;
  end

  // Request toggle, two stages before use
  always_ff @(posedge link_clk_i) begin
    if (!link_rstn_q) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
    end else begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
    end
  end

  // Config takes effect here; hold word is stable when the toggle lands
  always_ff @(posedge link_clk_i) begin
    if (!link_rstn_q) begin
      cfg_q <= audio_mux_pkg::CFG_RESET;
      seen_q <= 1'b0;
    end else if (cfg_load) begin
      cfg_q <= cfg_hold_q;
      seen_q <= req_s2_q;
    end
  end

  // ---------------------------------------------------------------
  // Pin input synchronisers
  // ---------------------------------------------------------------
  localparam int PIN_PF = 4;
  localparam int PIN_PB = 3;
  localparam int PIN_PD = 2;
  localparam int PIN_SO = 1;
  localparam int PIN_GP = 0;
  logic [audio_mux_pkg::PIN_COUNT-1:0] pin_s1_q;
  logic [audio_mux_pkg::PIN_COUNT-1:0] pin_s2_q;
  wire logic [audio_mux_pkg::PIN_COUNT-1:0] pin_raw = {prim_frame_pin_i,
    prim_bit_pin_i, prim_din_pin_i, sout_pin_i, general_pin_one_i};

  // Pins are asynchronous to the link clock; first stage feeds only the second
  always_ff @(posedge link_clk_i) begin
    if (!link_rstn_q) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  wire logic pf_in = pin_s2_q[PIN_PF];
  wire logic pb_in = pin_s2_q[PIN_PB];
  wire logic pd_in = pin_s2_q[PIN_PD];
  wire logic so_in = pin_s2_q[PIN_SO];
  wire logic gp_in = pin_s2_q[PIN_GP];

  // ---------------------------------------------------------------
  // Source selection
  // ---------------------------------------------------------------
  audio_mux_pkg::pin_drive_s prim_frame_q;
  audio_mux_pkg::pin_drive_s prim_bit_q;
  audio_mux_pkg::pin_drive_s sout_q;
  audio_mux_pkg::pin_drive_s gp_q;
  logic iface_frame_q;
  logic iface_bit_q;
  logic iface_din_q;
  logic rec_frame_q;

  wire logic gp_sec_in = gp_is_input(cfg_q.gp_func);
  wire logic sout_in_mode = !sout_q.oe;

  // Primary clocks as seen inside: own drive or the pin
  wire logic prim_frame_now = cfg_q.prim_frame_dir ? prim_frame_q.level : pf_in;
  wire logic prim_bit_now = cfg_q.prim_bit_dir ? prim_bit_q.level : pb_in;

  wire logic sec_frame_from_gp = (cfg_q.sec_frame_pin == audio_mux_pkg::PIN_SRC_GENERAL) &&
                                 gp_sec_in;
  wire logic sec_frame_from_so = (cfg_q.sec_frame_pin == audio_mux_pkg::PIN_SRC_SOUT) &&
                                 sout_in_mode;
  wire logic sec_frame_in = sec_frame_from_gp ? gp_in : (sec_frame_from_so ? so_in : 1'b0);

  wire logic sec_bit_from_gp = (cfg_q.sec_bit_pin == audio_mux_pkg::PIN_SRC_GENERAL) &&
                               gp_sec_in;
  wire logic sec_bit_from_so = (cfg_q.sec_bit_pin == audio_mux_pkg::PIN_SRC_SOUT) &&
                               sout_in_mode;
  wire logic sec_bit_in = sec_bit_from_gp ? gp_in : (sec_bit_from_so ? so_in : 1'b0);

  wire logic prim_frame_drv = frame_pick(cfg_q.prim_frame_src, playback_rate_clock_i,
                                         record_rate_clock_i, sec_frame_in);
  wire logic sec_frame_drv = frame_pick(cfg_q.sec_frame_src, playback_rate_clock_i,
                                        record_rate_clock_i, prim_frame_now);
  wire logic prim_bit_drv = cfg_q.prim_bit_src ? sec_bit_in : int_bit_clock_i;
  wire logic sec_bit_drv = cfg_q.sec_bit_src ? int_bit_clock_i : prim_bit_now;

  // secondary data only from an input-mode general pin
  wire logic sec_din = (cfg_q.sec_din_pin == audio_mux_pkg::SEC_DIN_GENERAL) && gp_sec_in &&
                       gp_in;
  wire logic iface_din = cfg_q.iface_din_sel ? sec_din : pd_in;
  wire logic prim_dout = cfg_q.prim_dout_sel ? sec_din : iface_dout_i;
  wire logic sec_dout = cfg_q.sec_dout_sel ? iface_dout_i : pd_in;

  // record frame tied to general pin in either direction
  wire logic rec_on_gp = (cfg_q.rec_frame_pin == audio_mux_pkg::PIN_SRC_GENERAL);
  wire logic rec_frame_ext = (rec_on_gp && gp_sec_in) ? gp_in : record_rate_clock_i;
  wire logic rec_frame_int = cfg_q.rec_frame_sel ? rec_frame_ext : prim_frame_now;

  // ---------------------------------------------------------------
  // Pin drive decode
  // ---------------------------------------------------------------
  // unknown codes leave a pin undriven
  wire audio_mux_pkg::pin_drive_s sout_d =
    (cfg_q.sout_func == audio_mux_pkg::SOUT_PRIM_DATA) ? {1'b1, prim_dout} :
    (cfg_q.sout_func == audio_mux_pkg::SOUT_SEC_BIT) ? {1'b1, sec_bit_drv} :
    (cfg_q.sout_func == audio_mux_pkg::SOUT_SEC_FRAME) ? {1'b1, sec_frame_drv} :
    audio_mux_pkg::PIN_IDLE;

  // general pin secondary clocks, data and record frame
  wire audio_mux_pkg::pin_drive_s gp_d =
    (cfg_q.gp_func == audio_mux_pkg::GP_SEC_BIT) ? {1'b1, sec_bit_drv} :
    (cfg_q.gp_func == audio_mux_pkg::GP_SEC_FRAME) ? {1'b1, sec_frame_drv} :
    (cfg_q.gp_func == audio_mux_pkg::GP_SEC_DOUT) ? {1'b1, sec_dout} :
    (cfg_q.gp_func == audio_mux_pkg::GP_REC_FRAME && rec_on_gp) ?
      {1'b1, rec_frame_int} :
    audio_mux_pkg::PIN_IDLE;

  wire audio_mux_pkg::pin_drive_s prim_frame_d = cfg_q.prim_frame_dir ?
    {1'b1, prim_frame_drv} : audio_mux_pkg::PIN_IDLE;
  wire audio_mux_pkg::pin_drive_s prim_bit_d = cfg_q.prim_bit_dir ?
    {1'b1, prim_bit_drv} : audio_mux_pkg::PIN_IDLE;

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------

  // Registered drives; adds one link cycle of delay but keeps outputs glitch free
  always_ff @(posedge link_clk_i) begin
    if (!link_rstn_q) begin
      prim_frame_q <= audio_mux_pkg::PIN_IDLE;
      prim_bit_q <= audio_mux_pkg::PIN_IDLE;
      sout_q <= audio_mux_pkg::PIN_IDLE;
      gp_q <= audio_mux_pkg::PIN_IDLE;
    end else begin
      prim_frame_q <= prim_frame_d;
      prim_bit_q <= prim_bit_d;
      sout_q <= sout_d;
      gp_q <= gp_d;
    end
  end

  // Signals handed to the internal interface block
  always_ff @(posedge link_clk_i) begin
    if (!link_rstn_q) begin
      iface_frame_q <= 1'b0;
      iface_bit_q <= 1'b0;
      iface_din_q <= 1'b0;
      rec_frame_q <= 1'b0;
    end else begin
      iface_frame_q <= prim_frame_now;
      iface_bit_q <= prim_bit_now;
      iface_din_q <= iface_din;
      rec_frame_q <= rec_frame_int;
    end
  end

  // Pin ports
  assign prim_frame_pin_o = prim_frame_q.level;
  assign prim_frame_pin_oe_o = prim_frame_q.oe;
  assign prim_bit_pin_o = prim_bit_q.level;
  assign prim_bit_pin_oe_o = prim_bit_q.oe;
  assign sout_pin_o = sout_q.level;
  assign sout_pin_oe_o = sout_q.oe;
  assign general_pin_one_o = gp_q.level;
  assign general_pin_one_oe_o = gp_q.oe;

  // Internal side ports
  assign iface_frame_o = iface_frame_q;
  assign iface_bit_o = iface_bit_q;
  assign iface_din_o = iface_din_q;
  assign rec_frame_o = rec_frame_q;

endmodule

`default_nettype wire

// ---- audio_port_dual_host_mux_assertions.sv ----
// Checker for the link side of the dual host audio pin mux
`timescale 1ns/10ps
`default_nettype none
module audio_port_dual_host_mux_assertions (
  input wire logic rstn_i,
  input wire audio_mux_pkg::mux_cfg_s cfg_i,
  input wire logic cfg_busy_o,
  input wire logic link_clk_i,
  input wire logic playback_rate_clock_i,
  input wire logic record_rate_clock_i,
  input wire logic int_bit_clock_i,
  input wire logic iface_dout_i,
  input wire logic prim_frame_pin_o,
  input wire logic prim_frame_pin_oe_o,
  input wire logic prim_bit_pin_o,
  input wire logic prim_bit_pin_oe_o,
  input wire logic sout_pin_o,
  input wire logic sout_pin_oe_o,
  input wire logic general_pin_one_o,
  input wire logic general_pin_one_oe_o,
  input wire logic rec_frame_o
);
  // ----------------
  // Settle tracking
  // ----------------
  // Quiet link edges; hides the config crossing and the link reset tail
  audio_mux_pkg::mux_cfg_s last_q;
  logic [2:0] quiet_q;
  logic ok;
  always_ff @(posedge link_clk_i) begin
    last_q <= cfg_i;
    if (!rstn_i || cfg_busy_o || cfg_i != last_q) begin
      quiet_q <= 3'h0;
    end else if (quiet_q != 3'h7) begin
      quiet_q <= quiet_q + 3'h1;
    end
  end
  // Current sample must agree too: a change just before the edge has not yet cleared the count
  assign ok = (quiet_q == 3'h7) && (cfg_i == last_q) && !cfg_busy_o;
  default clocking cb @(posedge link_clk_i);
  endclocking
  default disable iff (!rstn_i);
  // Pin drives and the record frame output against config, one link cycle after the source
  chk_frame_oe: assert property (
    ok |-> prim_frame_pin_oe_o == cfg_i.prim_frame_dir) else $error("frame enable wrong");
  chk_frame_rate: assert property (
    ok && cfg_i.prim_frame_dir && cfg_i.prim_frame_src != 2'h2 |-> prim_frame_pin_o ==
    (cfg_i.prim_frame_src == 2'h1 ? $past(record_rate_clock_i) : $past(playback_rate_clock_i)))
    else $error("frame source wrong");
  chk_bit_int: assert property (
    ok && prim_bit_pin_oe_o && !cfg_i.prim_bit_src |-> prim_bit_pin_o == $past(int_bit_clock_i))
    else $error("bit clock source wrong");
  chk_sout_data: assert property (
    ok && cfg_i.sout_func == 3'h1 && !cfg_i.prim_dout_sel
    |-> sout_pin_oe_o && sout_pin_o == $past(iface_dout_i)) else $error("serial out wrong");
  chk_gp_idle: assert property (
    ok && !(cfg_i.gp_func inside {4'h7, 4'h8, 4'h9, 4'hb}) |-> !general_pin_one_oe_o)
    else $error("general pin driven");
  chk_sout_idle: assert property (
    ok && !(cfg_i.sout_func inside {3'h1, 3'h6, 3'h7}) |-> !sout_pin_oe_o)
    else $error("serial out pin driven");
  chk_gp_bit: assert property (
    ok && cfg_i.gp_func == 4'h8 && cfg_i.sec_bit_src
    |-> general_pin_one_oe_o && general_pin_one_o == $past(int_bit_clock_i))
    else $error("general pin bit clock wrong");
  chk_rec_sel: assert property (
    ok && cfg_i.rec_frame_sel && cfg_i.rec_frame_pin != 3'h0
    |-> rec_frame_o == $past(record_rate_clock_i)) else $error("record frame wrong");
  // Main scenarios reached
  cov_frame_out: cover property (ok && prim_frame_pin_oe_o);
  cov_gp_out: cover property (ok && general_pin_one_oe_o);
  cov_sout_out: cover property (ok && sout_pin_oe_o);
endmodule
`default_nettype wire

// ---- audio_host_model.sv ----
// Behavioural model of the two hosts sharing the audio port
`timescale 1ns/10ps
`default_nettype none
module audio_host_model (
  input wire logic link_clk_i,
  input wire logic sec_active_i,
  input wire logic prim_level_i,
  input wire logic sec_level_i,
  input wire audio_mux_pkg::pin_drive_s frame_drv_i,
  input wire audio_mux_pkg::pin_drive_s bit_drv_i,
  input wire audio_mux_pkg::pin_drive_s sout_drv_i,
  input wire audio_mux_pkg::pin_drive_s gp_drv_i,
  output logic frame_o,
  output logic bit_o,
  output logic din_o,
  output logic sout_o,
  output logic gp_o
);
  // ----------------
  // Host lines
  // ----------------
  // Released lines toggle, so a stale level never reads as data
  logic idle_q = 1'b0;
  logic prim_line, sec_line;
  always @(negedge link_clk_i) idle_q <= ~idle_q;
  assign prim_line = sec_active_i ? idle_q : prim_level_i;
  assign sec_line = sec_active_i ? sec_level_i : ~idle_q;
  // Wire level: the device drive wins over the host
  assign frame_o = frame_drv_i.oe ? frame_drv_i.level : prim_line;
  assign bit_o = bit_drv_i.oe ? bit_drv_i.level : prim_line;
  assign din_o = prim_line;
  assign sout_o = sout_drv_i.oe ? sout_drv_i.level : sec_line;
  assign gp_o = gp_drv_i.oe ? gp_drv_i.level : sec_line;
endmodule
`default_nettype wire

// ---- audio_port_dual_host_mux_tb.sv ----
// Self-checking bench for the dual host audio pin mux
`timescale 1ns/10ps
`default_nettype none
module audio_port_dual_host_mux_tb;
  logic clock_i = 1'b0;
  logic lclk = 1'b0;
  logic rstn_i, busy, play, rec, ibit, idout, sec_act, plv, slv;
  logic iface_frame_o, iface_bit_o, iface_din_o, rec_frame_o;
  wire logic w_fr, w_bt, w_din, w_so, w_gp;
  wire audio_mux_pkg::pin_drive_s fd, bd, sd, gd;
  audio_mux_pkg::mux_cfg_s cfg, c;
  int n_errors = 0;
  int checks_done = 0;
  logic [2:0] sout_tab [5] = '{3'h1, 3'h1, 3'h6, 3'h7, 3'h2};
  logic [3:0] gp_tab [8] = '{4'h8, 4'h8, 4'h9, 4'hb, 4'hb, 4'h7, 4'h3, 4'h7};
  // ----------------
  // Clocks and parts
  // ----------------
  // Control clock 200 MHz, link clock 48 ns, phases unrelated
  always #2.5 clock_i = ~clock_i;
  // Offset keeps link edges off the stimulus edges, so no race at the sample
  initial begin
    #0.7;
    forever #24 lclk = ~lclk;
  end
  audio_port_dual_host_mux dut_u (.clock_i, .rstn_i, .cfg_i(cfg), .cfg_busy_o(busy),
    .link_clk_i(lclk), .playback_rate_clock_i(play), .record_rate_clock_i(rec),
    .int_bit_clock_i(ibit), .iface_dout_i(idout), .prim_frame_pin_i(w_fr),
    .prim_frame_pin_o(fd.level), .prim_frame_pin_oe_o(fd.oe), .prim_bit_pin_i(w_bt),
    .prim_bit_pin_o(bd.level), .prim_bit_pin_oe_o(bd.oe), .prim_din_pin_i(w_din),
    .sout_pin_i(w_so), .sout_pin_o(sd.level), .sout_pin_oe_o(sd.oe),
    .general_pin_one_i(w_gp), .general_pin_one_o(gd.level), .general_pin_one_oe_o(gd.oe),
    .iface_frame_o, .iface_bit_o, .iface_din_o, .rec_frame_o);
  audio_host_model host_u (.link_clk_i(lclk), .sec_active_i(sec_act), .prim_level_i(plv),
    .sec_level_i(slv), .frame_drv_i(fd), .bit_drv_i(bd), .sout_drv_i(sd), .gp_drv_i(gd),
    .frame_o(w_fr), .bit_o(w_bt), .din_o(w_din), .sout_o(w_so), .gp_o(w_gp));
  // Compare and count
  task automatic check(input string what, input logic seen, input logic exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %b seen %b", what, exp, seen);
    end
  endtask
  // Config write: bounded wait on busy, then settle beyond the pin latency
  task automatic apply();
    int k;
    k = 0;
    @(negedge clock_i);
    cfg = c;
    repeat (3) @(negedge clock_i);
    while (busy !== 1'b0 && k < 500) begin
      @(negedge clock_i);
      k++;
    end
    check("config idle", busy, 1'b0);
    repeat (8) @(posedge lclk);
    @(negedge clock_i);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Watchdog well beyond the run length of about 12 us
  initial begin
    #200000;
    n_errors++;
    close_out();
  end
  // Main sequence; reset held long enough to clear the link side too
  initial begin
    {rstn_i, play, rec, ibit, idout, sec_act, plv, slv} = 8'h00;
    cfg = '0;
    c = '0;
    repeat (40) @(negedge clock_i);
    rstn_i = 1'b1;
    repeat (4) @(posedge lclk);
    for (int v = 0; v < 2; v++) begin
      plv = v[0];
      apply();
      check("frame oe", fd.oe, 1'b0);
      check("gp oe", gd.oe, 1'b0);
      check("sout oe", sd.oe, 1'b0);
      check("iface frame", iface_frame_o, v[0]);
      check("iface bit", iface_bit_o, v[0]);
      check("iface din", iface_din_o, v[0]);
      check("rec frame", rec_frame_o, v[0]);
    end
    // Primary clocks driven, secondary taken from the general pin
    {c.prim_frame_dir, c.prim_bit_dir, c.iface_din_sel, c.gp_func} = 7'h71;
    {sec_act, play} = 2'h3;
    for (int s = 0; s < 4; s++) begin
      c.prim_frame_src = s[1:0];
      c.prim_bit_src = s[0];
      slv = s[0] ^ s[1];
      ibit = s != 1;
      apply();
      check("prim frame", fd.level, s != 1);
      check("bit oe", bd.oe, 1'b1);
      check("prim bit", bd.level, s != 3);
      check("iface din sec", iface_din_o, s == 1 || s == 2);
    end
    // Secondary clocks from the serial-out pin; general pin unused
    {c.sec_frame_pin, c.sec_bit_pin, c.prim_frame_src, c.gp_func} = 12'h6e0;
    for (int v = 0; v < 2; v++) begin
      slv = v[0];
      apply();
      check("frame via sout", fd.level, v[0]);
      check("bit via sout", bd.level, v[0]);
      check("sec din off", iface_din_o, 1'b0);
      check("gp idle", gd.oe, 1'b0);
    end
    {c.sec_frame_pin, c.sec_bit_pin, c.gp_func, c.sec_frame_src, c.sec_bit_src} = 13'h0013;
    {idout, ibit, rec, play, slv} = 5'h1c;
    for (int j = 0; j < 5; j++) begin
      c.sout_func = sout_tab[j];
      c.prim_dout_sel = j == 1;
      apply();
      check("sout oe", sd.oe, j != 4);
      if (j < 4) check("sout level", sd.level, j != 1);
    end
    // General pin functions with the primary host active
    {c.prim_bit_dir, c.sout_func, c.rec_frame_sel, c.sec_frame_src} = 7'h04;
    {sec_act, plv} = 2'h0;
    for (int k = 0; k < 8; k++) begin
      c.gp_func = gp_tab[k];
      c.sec_bit_src = k == 0;
      c.sec_dout_sel = k == 4;
      c.rec_frame_pin = (k == 7) ? 3'h1 : 3'h0;
      apply();
      check("gp oe", gd.oe, k < 6);
      if (k < 6) check("gp level", gd.level, k == 0 || k == 4 || k == 5);
    end
    // Record frame taken in from the general pin
    {c.gp_func, sec_act, slv, rec} = 7'h0e;
    for (int v = 0; v < 2; v++) begin
      c.rec_frame_pin = v[2:0];
      apply();
      check("rec frame in", rec_frame_o, v == 0);
    end
    close_out();
  end
endmodule
bind audio_port_dual_host_mux audio_port_dual_host_mux_assertions chk_u (.rstn_i, .cfg_i,
  .cfg_busy_o, .link_clk_i, .playback_rate_clock_i, .record_rate_clock_i, .int_bit_clock_i,
  .iface_dout_i, .prim_frame_pin_o, .prim_frame_pin_oe_o, .prim_bit_pin_o,
  .prim_bit_pin_oe_o, .sout_pin_o, .sout_pin_oe_o, .general_pin_one_o,
  .general_pin_one_oe_o, .rec_frame_o);
`default_nettype wire
